// >>> hw/frame_decoder_pkg.sv
// frame_decoder_pkg: constants shared by the binary message decoder
// assumes: byte-wide receive stream, 16-bit register words
package frame_decoder_pkg;
  localparam logic [7:0]  ADDR_ZERO      = 8'h00;
  localparam logic [7:0]  ADDR_ONE       = 8'h01;
  localparam logic [7:0]  ERR_LAST       = 8'h29;
  localparam logic [7:0]  TEXT_FIRST     = 8'h2A;
  localparam logic [7:0]  FC_WRITE_REG   = 8'h06;
  localparam logic [15:0] CRC_INIT       = 16'hFFFF;
  localparam logic [15:0] CRC_POLY       = 16'hA001;
  localparam logic [15:0] PCT_FULL       = 16'hCCCC;
  localparam logic [15:0] PCT_SET_MAX    = 16'hD0E5;
  localparam logic [15:0] PCT_ALARM_MAX  = 16'hE147;
  localparam logic [15:0] PCT_READ_MAX   = 16'hFFFF;
  localparam logic [2:0]  RTU_WRITE_LEN  = 3'h6;
  localparam logic [2:0]  TCP_HDR_LEN    = 3'h6;
  localparam logic [2:0]  TCP_WRITE_LEN  = 3'h6;
  localparam logic [1:0]  KIND_SET       = 2'h0;
  localparam logic [1:0]  KIND_ALARM     = 2'h1;
  localparam logic [1:0]  KIND_SWITCH    = 2'h2;
  localparam logic [1:0]  KIND_OTHER     = 2'h3;
endpackage

// >>> hw/crc16_step.sv
// crc16_step: one byte of reflected CRC-16 per cycle, combinational
// assumes: caller holds the running value in its own register
`timescale 1ns/1ns
module crc16_step
  import frame_decoder_pkg::*;
(
  // running value and byte
  input  wire logic [15:0] crcIn,
  input  wire logic [7:0]  dataIn,
  // updated value
  output logic      [15:0] crcOut
);
  always_comb begin
    logic [15:0] c;
    c = crcIn ^ {8'h00, dataIn};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    crcOut = c;
  end
endmodule // crc16_step

// >>> hw/modbus_frame_decoder.sv
// modbus_frame_decoder: first-byte routing, framing and write checking
// assumes: frame boundaries come from the transport (frameEnd strobe),
// limits and register class come from surrounding logic on clk
`timescale 1ns/1ns
module modbus_frame_decoder
  import frame_decoder_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // receive stream
  input  wire logic        rxValid,
  input  wire logic [7:0]  rxData,
  input  wire logic        frameEnd,
  input  wire logic        tcpMode,
  // configuration and gate
  input  wire logic        fullCompliance,
  input  wire logic        remoteActive,
  input  wire logic [1:0]  regKind,
  input  wire logic [15:0] userLimit,
  // text path
  output logic             textValid,
  output logic [7:0]       textData,
  // decode results
  output logic             commError,
  output logic             crcError,
  output logic             writeValid,
  output logic [15:0]      writeReg,
  output logic [15:0]      writeWord,
  output logic             writeReject,
  output logic             echoValid,
  output logic [7:0]       echoAddr,
  output logic             queryValid,
  output logic [7:0]       queryFunc
);
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001, S_HDR = 5'b00010, S_BIN = 5'b00100,
    S_TEXT = 5'b01000, S_DROP = 5'b10000
  } state_t;

  state_t      state_reg;
  logic [2:0]  hdrCnt_reg;
  logic [2:0]  binCnt_reg;
  logic        binOver_reg;
  logic [7:0]  addr_reg;
  logic [7:0]  func_reg;
  logic [15:0] num_reg;
  logic [15:0] word_reg;
  logic [15:0] crc_reg;
  logic [15:0] crcNext;
  logic [15:0] lastTwo_reg;
  logic [15:0] crcLag_reg;
  logic [15:0] crcLag2_reg;

  // address acceptance, USB line coding never enters here
  function automatic logic addrOk(input logic [7:0] a, input logic full);
    addrOk = (a == ADDR_ZERO) || (full && a == ADDR_ONE);
  endfunction

  function automatic logic [15:0] kindMax(input logic [1:0] k);
    case (k)
      KIND_SET:   kindMax = PCT_SET_MAX;
      KIND_ALARM: kindMax = PCT_ALARM_MAX;
      default:    kindMax = PCT_READ_MAX;
    endcase
  endfunction

  crc16_step crcStep (
    .crcIn  (crc_reg),
    .dataIn (rxData),
    .crcOut (crcNext)
  );

  wire logic startByte = rxValid && (state_reg == S_IDLE);

  // framing state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= S_IDLE;
    end else if (frameEnd) begin
      state_reg <= S_IDLE;
    end else if (rxValid) begin
      case (state_reg)
        S_IDLE: begin
          if (tcpMode) state_reg <= S_HDR;
          else if (rxData >= TEXT_FIRST) state_reg <= S_TEXT;
          else if (addrOk(rxData, fullCompliance)) state_reg <= S_BIN;
          else state_reg <= S_DROP;
        end
        S_HDR: begin
          if (hdrCnt_reg == TCP_HDR_LEN) begin
            if (addrOk(rxData, fullCompliance)) state_reg <= S_BIN;
            else state_reg <= S_DROP;
          end
        end
        S_BIN:   state_reg <= S_BIN;
        S_TEXT:  state_reg <= S_TEXT;
        S_DROP:  state_reg <= S_DROP;
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // byte counters
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hdrCnt_reg <= 3'h0;
      binCnt_reg <= 3'h0;
    end else if (frameEnd) begin
      hdrCnt_reg <= 3'h0;
      binCnt_reg <= 3'h0;
    end else if (rxValid) begin
      if (startByte) hdrCnt_reg <= 3'h1;
      else if (state_reg == S_HDR) hdrCnt_reg <= hdrCnt_reg + 3'h1;
      if (state_reg == S_BIN && binCnt_reg != 3'h7)
        binCnt_reg <= binCnt_reg + 3'h1;
    end
  end

  // overlong frame marker, the byte counter saturates
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      binOver_reg <= 1'b0;
    end else if (frameEnd) begin
      binOver_reg <= 1'b0;
    end else if (rxValid && state_reg == S_BIN && binCnt_reg == 3'h7) begin
      binOver_reg <= 1'b1;
    end
  end

  // PDU capture, same for every transport
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addr_reg <= ADDR_ZERO;
      func_reg <= 8'h00;
      num_reg  <= 16'h0000;
      word_reg <= 16'h0000;
    end else if (rxValid) begin
      if ((startByte && !tcpMode) ||
          (state_reg == S_HDR && hdrCnt_reg == TCP_HDR_LEN))
        addr_reg <= rxData;
      if (state_reg == S_BIN) begin
        case (binCnt_reg)
          3'h0:    func_reg        <= rxData;
          3'h1:    num_reg[15:8]   <= rxData;
          3'h2:    num_reg[7:0]    <= rxData;
          3'h3:    word_reg[15:8]  <= rxData;
          3'h4:    word_reg[7:0]   <= rxData;
          default: func_reg        <= func_reg;
        endcase
      end
    end
  end

  // CRC over all bytes; trailing two bytes compared with the CRC two bytes back
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      crc_reg     <= CRC_INIT;
      crcLag_reg  <= CRC_INIT;
      crcLag2_reg <= CRC_INIT;
      lastTwo_reg <= 16'h0000;
    end else if (frameEnd) begin
      crc_reg     <= CRC_INIT;
      crcLag_reg  <= CRC_INIT;
      crcLag2_reg <= CRC_INIT;
    end else if (rxValid) begin
      crc_reg     <= crcNext;
      crcLag_reg  <= crc_reg;
      crcLag2_reg <= crcLag_reg;
      lastTwo_reg <= {rxData, lastTwo_reg[15:8]}; // low byte first
    end
  end

  wire logic rtuLen  = !binOver_reg && binCnt_reg == RTU_WRITE_LEN + 3'h1;
  wire logic tcpLen  = binCnt_reg == TCP_WRITE_LEN - 3'h1;
  // CRC covers everything except the final two bytes
  wire logic crcGood = (lastTwo_reg == crcLag2_reg);
  wire logic binEnd  = frameEnd && state_reg == S_BIN;
  wire logic isWrite = func_reg == FC_WRITE_REG;
  wire logic lenOk   = tcpMode ? tcpLen : rtuLen;
  wire logic frameOk = binEnd && (tcpMode || crcGood);
  wire logic outOfRange = (word_reg > kindMax(regKind)) ||
                          (regKind != KIND_SWITCH &&
                           regKind != KIND_OTHER &&
                           word_reg > userLimit);

  // text passthrough
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      textValid <= 1'b0;
      textData  <= 8'h00;
    end else begin
      textValid <= rxValid && ((startByte && !tcpMode &&
                   rxData >= TEXT_FIRST) || state_reg == S_TEXT);
      textData  <= rxData;
    end
  end

  // result strobes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      commError   <= 1'b0;
      crcError    <= 1'b0;
      writeValid  <= 1'b0;
      writeReject <= 1'b0;
      echoValid   <= 1'b0;
      queryValid  <= 1'b0;
      writeReg    <= 16'h0000;
      writeWord   <= 16'h0000;
      echoAddr    <= ADDR_ZERO;
      queryFunc   <= 8'h00;
    end else begin
      commError   <= startByte && !tcpMode && rxData != ADDR_ZERO &&
                     rxData <= ERR_LAST &&
                     !addrOk(rxData, fullCompliance);
      crcError    <= binEnd && !tcpMode && !crcGood;
      writeValid  <= frameOk && isWrite && lenOk && remoteActive &&
                     !outOfRange;
      writeReject <= frameOk && isWrite && lenOk &&
                     (!remoteActive || outOfRange);
      echoValid   <= frameOk && isWrite && lenOk;
      queryValid  <= frameOk && !isWrite;
      writeReg    <= num_reg;
      writeWord   <= word_reg;
      echoAddr    <= addr_reg;
      queryFunc   <= func_reg;
    end
  end
endmodule // modbus_frame_decoder

// >>> bench/frame_decoder_properties.sv
// frame_decoder_properties: port checks of the frame decoder
// assumes: bound to modbus_frame_decoder, inputs steady per frame
`timescale 1ns/1ns
module frame_decoder_properties
  import frame_decoder_pkg::*;
(
  // all ports of the decoder
  input wire logic        clk, resetn, rxValid, frameEnd, tcpMode,
  input wire logic        fullCompliance, remoteActive, textValid,
  input wire logic        commError, crcError, writeValid, writeReject,
  input wire logic        echoValid, queryValid,
  input wire logic [1:0]  regKind,
  input wire logic [7:0]  rxData, textData, echoAddr, queryFunc,
  input wire logic [15:0] userLimit, writeReg, writeWord
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic firstReg;
  logic lead;
  // marks the first byte of a frame
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) firstReg <= 1'b1;
    else if (rxValid) firstReg <= 1'b0;
    else if (frameEnd) firstReg <= 1'b1;
  end
  assign lead = rxValid && firstReg;
  a_text_route: assert property (
    lead && !tcpMode && rxData >= TEXT_FIRST |=>
    textValid && textData == $past(rxData))
    else $error("text byte not routed");
  a_comm_error: assert property (
    lead && !tcpMode && rxData inside {[8'h02:ERR_LAST]} |=> commError)
    else $error("no error on bad first byte");
  a_zero_addr: assert property (
    lead && rxData == ADDR_ZERO |=> !commError && !textValid)
    else $error("address zero refused");
  a_gate_write: assert property (writeValid |-> $past(remoteActive))
    else $error("write without remote control");
  a_set_range: assert property (
    writeValid && $past(regKind) == KIND_SET |->
    writeWord <= PCT_SET_MAX && writeWord <= $past(userLimit))
    else $error("set value out of range");
  a_alarm_range: assert property (
    writeValid && $past(regKind) == KIND_ALARM |->
    writeWord <= PCT_ALARM_MAX && writeWord <= $past(userLimit))
    else $error("alarm value out of range");
  a_result_time: assert property (
    writeValid || writeReject || crcError || queryValid |-> $past(frameEnd))
    else $error("result not after frame end");
  a_echo_write: assert property (
    writeValid |-> echoValid && !writeReject && (echoAddr == ADDR_ZERO
    || fullCompliance && echoAddr == ADDR_ONE))
    else $error("write not echoed");
  c_write: cover property (writeValid);
  c_reject: cover property (writeReject);
  c_text: cover property (textValid);
endmodule // frame_decoder_properties

bind modbus_frame_decoder frame_decoder_properties chk (.clk, .resetn,
  .rxValid, .frameEnd, .tcpMode, .fullCompliance, .remoteActive,
  .textValid, .commError, .crcError, .writeValid, .writeReject,
  .echoValid, .queryValid, .regKind, .rxData, .textData, .echoAddr,
  .queryFunc, .userLimit, .writeReg, .writeWord);

// >>> bench/host_model.sv
// host_model: host side, sends framed register messages
// assumes: one frame at a time, bytes change at the falling edge
`timescale 1ns/1ns
module host_model (
  // stream to the decoder
  input  wire logic  clk,
  output logic       rxValid,
  output logic [7:0] rxData,
  output logic       frameEnd,
  output logic       tcpMode
);
  logic [15:0] crcReg;
  logic [15:0] crcHold;
  initial begin
    rxValid = 1'b0;
    rxData = 8'h00;
    frameEnd = 1'b0;
    tcpMode = 1'b0;
  end
  task automatic put(input logic [7:0] b);
    @(negedge clk);
    rxValid = 1'b1;
    rxData = b;
    crcReg = crcReg ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      crcReg = crcReg[0] ? (crcReg >> 1) ^ 16'hA001 : crcReg >> 1;
    end
  endtask
  task automatic send(input logic [7:0] m[$], input logic tcp, bad);
    @(negedge clk);
    tcpMode = tcp;
    if (tcp) begin
      foreach (m[i]) crcHold = 16'(m.size());
      put(8'h47); put(8'h11); put(8'h00); put(8'h00);
      put(8'h00); put(crcHold[7:0]);
    end
    crcReg = 16'hFFFF;
    foreach (m[i]) put(m[i]);
    crcHold = crcReg ^ {15'h0000, bad};
    if (!tcp) begin
      put(crcHold[7:0]);
      put(crcHold[15:8]);
    end
    @(negedge clk);
    rxValid = 1'b0;
    rxData = ~rxData;
    frameEnd = 1'b1;
    @(negedge clk);
    frameEnd = 1'b0;
  endtask
endmodule // host_model

// >>> bench/modbus_frame_decoder_tb_top.sv
// modbus_frame_decoder_tb_top: directed scenarios for the decoder
// assumes: host_model drives the stream, checker bound elsewhere
`timescale 1ns/1ns
module modbus_frame_decoder_tb_top;
  import frame_decoder_pkg::*;
  typedef logic [7:0] msg_t[$];
  localparam logic [6:0] W = 7'h40, R = 7'h20, E = 7'h10, C = 7'h08;
  localparam logic [6:0] Q = 7'h04, K = 7'h02, T = 7'h01;
  logic        clk = 1'b0, resetn = 1'b0;
  logic        fullCompliance = 1'b0, remoteActive = 1'b1;
  logic [1:0]  regKind = KIND_OTHER;
  logic [15:0] userLimit = 16'hFFFF;
  logic        rxValid, frameEnd, tcpMode, textValid, commError, crcError;
  logic        writeValid, writeReject, echoValid, queryValid;
  logic [7:0]  rxData, textData, echoAddr, queryFunc;
  logic [15:0] writeReg, writeWord;
  logic [6:0]  seen = 7'h00;
  int          bad_count = 0, n_tests = 0;
  always #2 clk = ~clk;
  always @(posedge clk) seen <= seen | {writeValid, writeReject,
    echoValid, commError, queryValid, crcError, textValid};
  host_model host (.clk, .rxValid, .rxData, .frameEnd, .tcpMode);
  modbus_frame_decoder dut (.clk, .resetn, .rxValid, .rxData, .frameEnd,
    .tcpMode, .fullCompliance, .remoteActive, .regKind, .userLimit,
    .textValid, .textData, .commError, .crcError, .writeValid, .writeReg,
    .writeWord, .writeReject, .echoValid, .echoAddr, .queryValid,
    .queryFunc);
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic msg_t wr(input logic [7:0] a, input logic [15:0] v);
    return {a, FC_WRITE_REG, 8'hFF, 8'hFF, v[15:8], v[7:0]};
  endfunction
  task automatic run(input msg_t m, input logic tcp, bad,
                     input logic [6:0] exp);
    int n;
    seen = 7'h00;
    host.send(m, tcp, bad);
    for (n = 0; n < 20 && seen == 7'h00; n++) @(negedge clk);
    if (n == 20) begin
      bad_count++;
      give_verdict();
    end else begin
      repeat (2) @(negedge clk);
      check({9'h000, seen}, {9'h000, exp});
    end
  endtask
  task automatic t_write();
    run(wr(ADDR_ZERO, 16'hABCD), 1'b0, 1'b0, W | E);
    check(writeReg, 16'hFFFF);
    check(writeWord, 16'hABCD);
    run(wr(ADDR_ZERO, 16'h1357), 1'b1, 1'b0, W | E);
    check(writeWord, 16'h1357);
    run(wr(ADDR_ZERO, 16'h0001), 1'b0, 1'b1, K);
    run({8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0, 1'b0, Q);
    check({8'h00, queryFunc}, 16'h0003);
  endtask
  task automatic t_lead();
    msg_t codes = {8'h01, 8'h02, 8'h29, 8'h2A, 8'h7F};
    foreach (codes[i]) run({codes[i]}, 1'b0, 1'b0, i < 3 ? C : T);
  endtask
  task automatic t_mode();
    fullCompliance = 1'b1;
    run(wr(ADDR_ONE, 16'h0100), 1'b0, 1'b0, W | E);
    check({8'h00, echoAddr}, 16'h0001);
    fullCompliance = 1'b0;
    remoteActive = 1'b0;
    run(wr(ADDR_ZERO, 16'h0100), 1'b0, 1'b0, R | E);
    remoteActive = 1'b1;
  endtask
  task automatic t_range();
    logic [1:0]  k[6] = '{KIND_SET, KIND_SET, KIND_ALARM, KIND_ALARM,
                          KIND_SET, KIND_SWITCH};
    logic [15:0] v[6] = '{16'hD0E5, 16'hD0E6, 16'hE147, 16'hE148, 16'h1001,
                          16'hFFFF};
    logic [6:0]  want[6] = '{W | E, R | E, W | E, R | E, R | E, W | E};
    logic [15:0] threeQuarter = 16'(32'(PCT_FULL) * 3 / 4);
    for (int i = 0; i < 6; i++) begin
      regKind = k[i];
      userLimit = i == 4 ? 16'h1000 : 16'hFFFF;
      run(wr(ADDR_ZERO, v[i]), 1'b0, 1'b0, want[i]);
    end
    regKind = KIND_SET;
    run(wr(ADDR_ZERO, threeQuarter), 1'b0, 1'b0, W | E);
    check(writeWord, 16'h9999);
  endtask
  initial begin
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    t_write();
    t_lead();
    t_mode();
    t_range();
    give_verdict();
  end
endmodule // modbus_frame_decoder_tb_top
